// file: src/gprf_pkg.sv
/*
 * Shared constants, types and register map of the GPIB reply formatter.
 * Assumes one 100 MHz clock and a synchronous active-high reset.
 */
package gprf_pkg;
	localparam logic [11:0] CTRL_OFS = 12'h000;
	localparam logic [11:0] MODE_OFS = 12'h004;
	localparam logic [11:0] STAT_OFS = 12'h008;
	localparam logic [11:0] PARAM_BASE = 12'h400;
	localparam logic [1:0] TERM_CRLF_EOI = 2'h0;
	localparam logic [1:0] TERM_LF = 2'h1;
	localparam logic [1:0] TERM_EOI = 2'h2;
	localparam logic [1:0] TERM_CRLF = 2'h3;
	localparam logic [1:0] TERM_RESET = TERM_CRLF;
	localparam logic HDR_RESET = 1'h1;
	localparam logic [12:0] MODE_RESET = 13'h0000;
	localparam logic [7:0] CHAR_LF = 8'h0A;
	localparam logic [7:0] CHAR_CR = 8'h0D;
	localparam logic [3:0] HDR_LAST = 4'h1;
	localparam logic [3:0] BODY_POS = 4'h2;
	localparam logic [3:0] BODY_MAX = 4'hD;
	localparam logic [3:0] LEN_POS = 4'hF;
	localparam logic [2:0] MODE_LAST = 3'h6;
	localparam logic [4:0] REPLY_MAX = 5'h11;

	typedef enum logic [1:0] {
		CMD_TERM = 2'b00,
		CMD_HDR = 2'b01,
		CMD_MODE = 2'b10,
		CMD_PARAM = 2'b11
	} gprf_kind_e;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0000,
		ST_PEND = 4'b0001,
		ST_LEN = 4'b0010,
		ST_HDR = 4'b0011,
		ST_BODY = 4'b0100,
		ST_CR = 4'b0101,
		ST_LF = 4'b0110,
		ST_MODE = 4'b0111
	} gprf_state_e;

	typedef struct packed {
		logic freqCtl;
		logic knob;
		logic [1:0] trig;
		logic fine;
		logic [2:0] unit;
		logic [1:0] scale;
		logic [2:0] att;
	} gprf_mode_s;

	typedef struct packed {
		logic eoi;
		logic [7:0] data;
	} gprf_tx_s;

	typedef struct packed {
		gprf_kind_e kind;
		logic [3:0] arg;
	} gprf_cmd_s;
endpackage

// file: src/gprf_param_mem.sv
/*
 * Byte store for parameter reply text, one write and one registered read port.
 * Assumes the writer and reader share clk; contents are undefined until written.
 */
`timescale 1ns/1ps
module gprf_param_mem import gprf_pkg::*; #(
	parameter int WIDTH = 8, // Word width
	parameter int DEPTH = 256 // Number of words
) (
	input wire logic clk, // System clock
	input wire logic wrEn, // Write strobe
	input wire logic [$clog2(DEPTH)-1:0] wrAddr, // Write address
	input wire logic [WIDTH-1:0] wrData, // Write data
	input wire logic [$clog2(DEPTH)-1:0] rdAddr, // Read address
	output logic [WIDTH-1:0] rdData // Read data, one cycle after address
);
	logic [WIDTH-1:0] store [DEPTH];

	always_ff @(posedge clk) begin
		if (wrEn) begin
			store[wrAddr] <= wrData;
		end
	end

	always_ff @(posedge clk) begin
		rdData <= store[rdAddr];
	end
endmodule

// file: src/gprf_cmd_end.sv
/*
 * Finds the end of each incoming command byte stream and reports its form.
 * Assumes incoming bytes are synchronous to clk, one per valid cycle.
 */
`timescale 1ns/1ps
module gprf_cmd_end import gprf_pkg::*; (
	input wire logic clk, // System clock
	input wire logic sys_rst, // Synchronous reset, active high
	input wire logic rxValid, // Incoming byte valid
	input wire logic [7:0] rxByte, // Incoming byte
	input wire logic rxEoi, // End-of-identify with the byte
	output logic cmdEnd, // Pulse after the closing byte
	output logic [1:0] endForm // Terminator form of the last command
);
	logic crSeen_r;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cmdEnd <= 1'h0;
			endForm <= TERM_RESET;
			crSeen_r <= 1'h0;
		end else begin
			cmdEnd <= rxValid && (rxByte == CHAR_LF || rxEoi);
			if (rxValid) begin
				crSeen_r <= rxByte == CHAR_CR;
				if (rxByte == CHAR_LF) begin
					endForm <= crSeen_r ? (rxEoi ? TERM_CRLF_EOI : TERM_CRLF) : TERM_LF;
				end else if (rxEoi) begin
					endForm <= TERM_EOI;
				end
			end
		end
	end
endmodule

// file: src/gprf_response_formatter.sv
/*
 * Reply formatter on the talker path: parameter replies with selectable terminator
 * and header, the mode string always ending in end-of-identify, plus its APB register slave.
 * Assumes decoded commands and the talker level arrive synchronous to clk,
 * and that the byte handshake outside takes a byte when txValid and txReady.
 */
`timescale 1ns/1ps
module gprf_response_formatter import gprf_pkg::*; #(
	parameter int SLOTS = 16 // Parameter reply slots
) (
	input wire logic clk, // System clock
	input wire logic sys_rst, // Synchronous reset, active high
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [11:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	input wire logic cmdValid, // Decoded command strobe
	input wire gprf_cmd_s cmd, // Decoded command
	input wire logic talker, // Addressed as talker
	input wire logic rxValid, // Incoming command byte valid
	input wire logic [7:0] rxByte, // Incoming command byte
	input wire logic rxEoi, // End-of-identify with incoming byte
	output logic cmdEnd, // End of incoming command
	output logic [1:0] cmdEndForm, // Form of that end
	input wire logic txReady, // Byte taken by the handshake
	output logic txValid, // Reply byte valid
	output gprf_tx_s txBeat // Reply byte and end-of-identify
);
	localparam int SW = $clog2(SLOTS);
	localparam int AW = SW + 4;
	localparam int WIN_BYTES = SLOTS * 64;

	gprf_state_e state_r;
	gprf_mode_s mode_r;
	gprf_mode_s modeSnap_r;
	logic [1:0] termSel_r;
	logic hdrEn_r;
	logic [1:0] termUse_r;
	logic hdrUse_r;
	logic pendMode_r;
	logic [SW-1:0] slot_r;
	logic [3:0] pos_r;
	logic [3:0] len_r;
	logic [3:0] lenNxt;
	logic waitRd_r;
	logic [7:0] rdData;
	logic [7:0] endCount_r;
	logic [4:0] replyBytes_r;
	logic [31:0] readMux;
	logic apbDone;
	logic apbWr;
	logic fire;
	logic accept;
	logic bodyLast;

	function automatic logic inWin(input logic [11:0] a);
		inWin = int'(a) >= int'(PARAM_BASE) && int'(a) < int'(PARAM_BASE) + WIN_BYTES;
	endfunction

	function automatic logic mapped(input logic [11:0] a);
		mapped = a[1:0] == 2'h0 && (a == CTRL_OFS || a == MODE_OFS || a == STAT_OFS || inWin(a));
	endfunction

	function automatic logic [7:0] modeByte(input gprf_mode_s m, input logic [2:0] i);
		case (i)
			3'h0: modeByte = {5'h00, m.att};
			3'h1: modeByte = {6'h00, m.scale};
			3'h2: modeByte = {5'h00, m.unit};
			3'h3: modeByte = {7'h00, m.fine};
			3'h4: modeByte = {6'h00, m.trig};
			3'h5: modeByte = {7'h00, m.knob};
			default: modeByte = {7'h00, m.freqCtl};
		endcase
	endfunction

	// APB slave: one wait state, answer registered
	assign apbDone = psel && penable && pready;
	assign apbWr = apbDone && pwrite && mapped(paddr);

	always_comb begin
		readMux = 32'h0000_0000;
		case (paddr)
			CTRL_OFS: readMux = {29'h0000_0000, hdrEn_r, termSel_r};
			MODE_OFS: readMux = {19'h0_0000, mode_r};
			STAT_OFS: readMux = {8'h00, endCount_r, 3'h0, pendMode_r, 4'(slot_r), 4'h0, state_r};
			default: readMux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pready <= 1'h0;
			pslverr <= 1'h0;
			prdata <= 32'h0000_0000;
		end else if (psel && penable && !pready) begin
			pready <= 1'h1;
			pslverr <= !mapped(paddr);
			prdata <= pwrite ? 32'h0000_0000 : readMux;
		end else begin
			pready <= 1'h0;
			pslverr <= 1'h0;
		end
	end

	// Terminator and header settings; a command wins over a register write
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			termSel_r <= TERM_RESET;
			hdrEn_r <= HDR_RESET;
		end else if (cmdValid && cmd.kind == CMD_TERM && cmd.arg < 4'h4) begin
			termSel_r <= cmd.arg[1:0];
		end else if (cmdValid && cmd.kind == CMD_HDR && cmd.arg < 4'h2) begin
			hdrEn_r <= cmd.arg[0];
		end else if (apbWr && paddr == CTRL_OFS) begin
			termSel_r <= pwdata[1:0];
			hdrEn_r <= pwdata[2];
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			mode_r <= MODE_RESET;
		end else if (apbWr && paddr == MODE_OFS) begin
			mode_r <= pwdata[12:0];
		end
	end

	gprf_param_mem #(
		.WIDTH(8),
		.DEPTH(SLOTS * 16)
	) u_mem (
		.clk(clk),
		.wrEn(apbWr && inWin(paddr)),
		.wrAddr(paddr[AW+1:2]),
		.wrData(pwdata[7:0]),
		.rdAddr({slot_r, pos_r}),
		.rdData(rdData)
	);

	gprf_cmd_end u_end (
		.clk(clk),
		.sys_rst(sys_rst),
		.rxValid(rxValid),
		.rxByte(rxByte),
		.rxEoi(rxEoi),
		.cmdEnd(cmdEnd),
		.endForm(cmdEndForm)
	);

	assign fire = txValid && txReady;
	assign bodyLast = pos_r == len_r + 4'h1;
	assign accept = cmdValid && state_r == ST_IDLE &&
		(cmd.kind == CMD_MODE || (cmd.kind == CMD_PARAM && int'(cmd.arg) < SLOTS));

	// Body length kept in 1..13 so a full reply stays within its limit
	always_comb begin
		lenNxt = rdData[3:0];
		if (rdData[7:4] != 4'h0 || rdData[3:0] > BODY_MAX) begin
			lenNxt = BODY_MAX;
		end else if (rdData[3:0] == 4'h0) begin
			lenNxt = 4'h1;
		end
	end

	// Reply sequencer and output byte register
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_r <= ST_IDLE;
			txValid <= 1'h0;
			txBeat <= '0;
			pos_r <= 4'h0;
			len_r <= 4'h1;
			waitRd_r <= 1'h0;
			slot_r <= '0;
			pendMode_r <= 1'h0;
			modeSnap_r <= MODE_RESET;
			termUse_r <= TERM_RESET;
			hdrUse_r <= HDR_RESET;
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (accept) begin
						pendMode_r <= cmd.kind == CMD_MODE;
						modeSnap_r <= mode_r;
						slot_r <= cmd.arg[SW-1:0];
						termUse_r <= termSel_r;
						hdrUse_r <= hdrEn_r;
						state_r <= ST_PEND;
					end
				end
				ST_PEND: begin
					if (talker) begin
						pos_r <= pendMode_r ? 4'h0 : LEN_POS;
						waitRd_r <= !pendMode_r;
						state_r <= pendMode_r ? ST_MODE : ST_LEN;
					end
				end
				ST_LEN: begin
					if (waitRd_r) begin
						waitRd_r <= 1'h0;
					end else begin
						len_r <= lenNxt;
						pos_r <= hdrUse_r ? 4'h0 : BODY_POS;
						waitRd_r <= 1'h1;
						state_r <= hdrUse_r ? ST_HDR : ST_BODY;
					end
				end
				ST_HDR, ST_BODY: begin
					if (waitRd_r) begin
						waitRd_r <= 1'h0;
					end else if (!txValid) begin
						txValid <= 1'h1;
						txBeat.data <= rdData;
						txBeat.eoi <= state_r == ST_BODY && bodyLast && termUse_r == TERM_EOI;
					end else if (fire) begin
						txValid <= 1'h0;
						if (state_r == ST_BODY && bodyLast) begin
							if (termUse_r == TERM_EOI) begin
								state_r <= ST_IDLE;
							end else if (termUse_r == TERM_LF) begin
								state_r <= ST_LF;
							end else begin
								state_r <= ST_CR;
							end
						end else begin
							pos_r <= pos_r + 4'h1;
							waitRd_r <= 1'h1;
							if (pos_r == HDR_LAST) begin
								state_r <= ST_BODY;
							end
						end
					end
				end
				ST_CR: begin
					if (!txValid) begin
						txValid <= 1'h1;
						txBeat <= '{eoi: 1'h0, data: CHAR_CR};
					end else if (fire) begin
						txValid <= 1'h0;
						state_r <= ST_LF;
					end
				end
				ST_LF: begin
					if (!txValid) begin
						txValid <= 1'h1;
						txBeat <= '{eoi: termUse_r == TERM_CRLF_EOI, data: CHAR_LF};
					end else if (fire) begin
						txValid <= 1'h0;
						state_r <= ST_IDLE;
					end
				end
				ST_MODE: begin
					if (!txValid) begin
						txValid <= 1'h1;
						txBeat.data <= modeByte(modeSnap_r, pos_r[2:0]);
						txBeat.eoi <= pos_r[2:0] == MODE_LAST;
					end else if (fire) begin
						txValid <= 1'h0;
						if (pos_r[2:0] == MODE_LAST) begin
							state_r <= ST_IDLE;
						end else begin
							pos_r <= pos_r + 4'h1;
						end
					end
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	// Bytes sent in the current reply
	always_ff @(posedge clk) begin
		if (sys_rst || state_r == ST_PEND) begin
			replyBytes_r <= 5'h00;
		end else if (fire && replyBytes_r != 5'h1F) begin
			replyBytes_r <= replyBytes_r + 5'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			endCount_r <= 8'h00;
		end else if (cmdEnd) begin
			endCount_r <= endCount_r + 8'h01;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	property p_lfOnly;
		fire && state_r == ST_LF && termUse_r == TERM_LF |-> !txBeat.eoi ##1 state_r == ST_IDLE;
	endproperty
	a_lfOnly: assert property (p_lfOnly) else $error("LF terminator carried end-of-identify");

	property p_eoiOnLast;
		fire && txBeat.eoi && state_r != ST_MODE && termUse_r == TERM_EOI
			|-> state_r == ST_BODY && bodyLast ##1 state_r == ST_IDLE;
	endproperty
	a_eoiOnLast: assert property (p_eoiOnLast) else $error("End-of-identify not on last body byte");

	property p_crThenLf;
		fire && state_r == ST_CR |-> !txBeat.eoi ##2 (txValid && txBeat.data == CHAR_LF);
	endproperty
	a_crThenLf: assert property (p_crThenLf) else $error("CR not followed by LF");

	property p_eoiWithLf;
		fire && state_r == ST_LF |-> txBeat.eoi == (termUse_r == TERM_CRLF_EOI);
	endproperty
	a_eoiWithLf: assert property (p_eoiWithLf) else $error("Wrong end-of-identify on LF");

	property p_powerOn;
		$past(sys_rst) |-> termSel_r == TERM_RESET && hdrEn_r == HDR_RESET && !txValid;
	endproperty
	a_powerOn: assert property (p_powerOn) else $error("Wrong terminator after reset");

	property p_termCmd;
		cmdValid && cmd.kind == CMD_TERM && cmd.arg < 4'h4 |=> {2'h0, termSel_r} == $past(cmd.arg);
	endproperty
	a_termCmd: assert property (p_termCmd) else $error("Terminator select not applied");

	property p_hdrCmd;
		cmdValid && cmd.kind == CMD_HDR && cmd.arg < 4'h2 |=> {3'h0, hdrEn_r} == $past(cmd.arg);
	endproperty
	a_hdrCmd: assert property (p_hdrCmd) else $error("Header switch not applied");

	property p_modeStart;
		state_r == ST_PEND && talker && pendMode_r
			|=> state_r == ST_MODE ##1 (txValid && txBeat.data == {5'h00, modeSnap_r.att});
	endproperty
	a_modeStart: assert property (p_modeStart) else $error("Mode string did not start");

	property p_modeEoi;
		fire && state_r == ST_MODE |-> txBeat.eoi == (pos_r[2:0] == MODE_LAST) && txBeat.data[7:3] == 5'h00;
	endproperty
	a_modeEoi: assert property (p_modeEoi) else $error("Mode byte or its end mark wrong");

	property p_replyMax;
		replyBytes_r <= REPLY_MAX;
	endproperty
	a_replyMax: assert property (p_replyMax) else $error("Reply longer than limit");

	property p_hold;
		state_r == ST_PEND && !talker |=> state_r == ST_PEND && $stable(slot_r) && $stable(pendMode_r);
	endproperty
	a_hold: assert property (p_hold) else $error("Pending reply changed before talker");

	c_modeDone: cover property (fire && state_r == ST_MODE && pos_r[2:0] == MODE_LAST);
	c_bodyEoi: cover property (fire && state_r == ST_BODY && txBeat.eoi);
	c_crlfEoi: cover property (fire && state_r == ST_LF && txBeat.eoi);
	c_headerOn: cover property (fire && state_r == ST_HDR);
endmodule

// file: verification/gprf_ctl_model.sv
/*
 * Bus controller model on the reply side: takes reply beats and keeps them.
 * Assumes the formatter holds txValid and txBeat until a beat is taken.
 */
`timescale 1ns/1ps
module gprf_ctl_model import gprf_pkg::*; (
	input wire logic clk, // System clock
	input wire logic sys_rst, // Synchronous reset, active high
	input wire logic txValid, // Reply beat valid
	input wire gprf_tx_s txBeat, // Reply beat
	input wire logic slow, // Stall every other cycle
	input wire logic clr, // Empty the capture store
	output logic txReady, // Beat taken
	output logic [7:0] count // Beats captured
);
	logic [8:0] got [0:31];
	logic tick;

	// Stalls on alternate cycles when slow, so the formatter must hold its beat
	assign txReady = slow ? tick : 1'b1;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tick <= 1'b0;
		end else begin
			tick <= ~tick;
		end
	end

	// Keeps every beat with its end-of-identify, whatever ending it expects
	always_ff @(posedge clk) begin
		if (sys_rst || clr) begin
			count <= 8'h00;
		end else if (txValid && txReady) begin
			got[count[4:0]] <= txBeat;
			count <= count + 8'h01;
		end
	end
endmodule

// file: verification/tb.sv
/*
 * Self-checking bench of the reply formatter: APB, commands and reply stream.
 * Assumes the controller model above stands on the reply handshake.
 */
`timescale 1ns/1ps
module tb import gprf_pkg::*;;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic cmdValid = 1'b0;
	gprf_cmd_s cmd = '0;
	logic talker = 1'b0;
	logic rxValid = 1'b0;
	logic [7:0] rxByte = 8'h00;
	logic rxEoi = 1'b0;
	logic cmdEnd;
	logic [1:0] cmdEndForm;
	logic txReady;
	logic txValid;
	gprf_tx_s txBeat;
	logic slow = 1'b0;
	logic clr = 1'b0;
	logic [7:0] count;
	int bad_count = 0;
	int check_count = 0;
	logic [31:0] rd;
	logic err;
	logic [8:0] exp [$];

	gprf_response_formatter #(.SLOTS(16)) i_gprf_response_formatter (.clk(clk), .sys_rst(sys_rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cmdValid(cmdValid), .cmd(cmd), .talker(talker),
		.rxValid(rxValid), .rxByte(rxByte), .rxEoi(rxEoi), .cmdEnd(cmdEnd), .cmdEndForm(cmdEndForm),
		.txReady(txReady), .txValid(txValid), .txBeat(txBeat));
	gprf_ctl_model i_gprf_ctl_model (.clk(clk), .sys_rst(sys_rst), .txValid(txValid), .txBeat(txBeat),
		.slow(slow), .clr(clr), .txReady(txReady), .count(count));

	initial begin
		forever #5 clk = ~clk;
	end

	task stop_test();
		if (bad_count == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task check(input logic [31:0] seen, input logic [31:0] want);
		check_count++;
		if (seen !== want) begin
			bad_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) begin
			bad_count++;
			stop_test();
		end
	endtask

	task send_cmd(input logic [1:0] kind, input logic [3:0] arg);
		@(posedge clk);
		cmdValid <= 1'b1;
		cmd <= '{gprf_kind_e'(kind), arg};
		@(posedge clk);
		cmdValid <= 1'b0;
	endtask

	task rx_byte(input logic [7:0] b, input logic e);
		@(posedge clk);
		rxValid <= 1'b1;
		rxByte <= b;
		rxEoi <= e;
		@(posedge clk);
		rxValid <= 1'b0;
		rxEoi <= 1'b0;
	endtask

	// Raises talker and compares the whole reply with the expected beats
	task take_reply();
		int n;
		repeat (6) @(posedge clk);
		check(count, 0);
		talker <= 1'b1;
		n = 0;
		while (count < exp.size() && n < 400) begin
			@(posedge clk);
			n++;
		end
		talker <= 1'b0;
		if (n >= 400) begin
			bad_count++;
			stop_test();
		end
		repeat (12) @(posedge clk);
		check(count, exp.size());
		for (int i = 0; i < exp.size(); i++) begin
			check(i_gprf_ctl_model.got[i], exp[i]);
		end
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
	endtask

	initial begin
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		apb(1'b0, CTRL_OFS, 32'h0);
		check(rd, 32'h00000007);
		apb(1'b0, 12'h0F0, 32'h0);
		check(err, 1'b1);
		check(rd, 32'h0);
		// Slot 0 text: two header letters, body 123, length 3
		apb(1'b1, PARAM_BASE, 32'h43);
		apb(1'b1, PARAM_BASE + 12'h004, 32'h46);
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, PARAM_BASE + 12'h008 + 12'(i * 4), 32'h31 + i);
		end
		apb(1'b1, PARAM_BASE + 12'h03C, 32'h3);
		for (int t = 0; t < 4; t++) begin
			slow <= t[0];
			send_cmd(2'h0, 4'(t));
			send_cmd(2'h1, {3'h0, t != 1});
			send_cmd(2'h3, 4'h0);
			exp = {};
			if (t != 1) begin
				exp = {9'h043, 9'h046};
			end
			exp.push_back(9'h031);
			exp.push_back(9'h032);
			exp.push_back({t == 2, 8'h33});
			if (t != 2 && t != 1) begin
				exp.push_back({1'b0, CHAR_CR});
			end
			if (t != 2) begin
				exp.push_back({t == 0, CHAR_LF});
			end
			take_reply();
		end
		// Mode string under CRLF, with a second query dropped while pending
		send_cmd(2'h0, 4'h3);
		apb(1'b1, MODE_OFS, {19'h0, 1'b1, 1'b1, 2'h3, 1'b1, 3'h7, 2'h2, 3'h5});
		slow <= 1'b1;
		send_cmd(2'h2, 4'h0);
		send_cmd(2'h3, 4'h0);
		exp = {9'h005, 9'h002, 9'h007, 9'h001, 9'h003, 9'h001, 9'h101};
		take_reply();
		// Register write of the settings, then an out-of-range select that must be ignored
		apb(1'b1, CTRL_OFS, 32'h2);
		send_cmd(2'h0, 4'h5);
		apb(1'b0, CTRL_OFS, 32'h0);
		check(rd, 32'h00000002);
		// Incoming command endings of all four forms
		rx_byte(8'h48, 1'b0);
		rx_byte(CHAR_LF, 1'b0);
		@(posedge clk);
		check(cmdEnd, 1'b1);
		@(posedge clk);
		check(cmdEnd, 1'b0);
		check(cmdEndForm, 2'h1);
		rx_byte(CHAR_CR, 1'b0);
		rx_byte(CHAR_LF, 1'b1);
		repeat (2) @(posedge clk);
		check(cmdEndForm, 2'h0);
		rx_byte(8'h30, 1'b1);
		repeat (2) @(posedge clk);
		check(cmdEndForm, 2'h2);
		rx_byte(CHAR_CR, 1'b0);
		rx_byte(CHAR_LF, 1'b0);
		repeat (2) @(posedge clk);
		check(cmdEndForm, 2'h3);
		apb(1'b0, STAT_OFS, 32'h0);
		check(rd[23:16], 8'h04);
		stop_test();
	end
endmodule
